// >>> hw/bcx_pkg.sv
// Package for the bit, residual, translate and list-add execution datapath
package bcx_pkg;

	// Opcodes handled by the datapath
	localparam logic [7:0] OP_TEST_BIT = 8'h74;
	localparam logic [7:0] OP_SET_BIT = 8'h75;
	localparam logic [7:0] OP_CLEAR_BIT = 8'h76;
	localparam logic [7:0] OP_INVERT_BIT = 8'h77;
	localparam logic [7:0] OP_CHECK_TWELVE = 8'h5e;
	localparam logic [7:0] OP_CHECK_SIXTEEN = 8'h5f;
	localparam logic [7:0] OP_TRANSLATE = 8'he7;
	localparam logic [7:0] OP_LIST_TOP = 8'h64;
	localparam logic [7:0] OP_LIST_BOTTOM = 8'h65;

	// Reflected generator constants and bit counts for the residuals
	localparam logic [15:0] POLY_TWELVE = 16'h0f01;
	localparam logic [15:0] POLY_SIXTEEN = 16'ha001;
	localparam logic [3:0] BITS_TWELVE = 4'h6;
	localparam logic [3:0] BITS_SIXTEEN = 4'h8;

	// Condition code patterns (C V G L)
	localparam logic [3:0] CC_ZERO = 4'h0;
	localparam logic [3:0] CC_GREATER = 4'h2;
	localparam logic [3:0] CC_OVERFLOW = 4'h4;

	// List header layout: byte offsets from the list base
	localparam logic [23:0] HDR_SLOTS_OFS = 24'h000000;
	localparam logic [23:0] HDR_USED_OFS = 24'h000002;
	localparam logic [23:0] HDR_TOP_OFS = 24'h000004;
	localparam logic [23:0] HDR_BOTTOM_OFS = 24'h000006;
	localparam logic [23:0] LIST_SLOT0_OFS = 24'h000008;

	// Memory access sizes
	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_HALF = 2'h1,
		SZ_WORD = 2'h2
	} bcx_size_type;

	// Request from the processor
	typedef struct packed {
		logic [7:0] opcode;
		logic [31:0] operand;
		logic [23:0] address;
	} bcx_cmd_type;

	// Memory request toward main memory
	typedef struct packed {
		logic write;
		bcx_size_type size;
		logic [23:0] address;
		logic [31:0] data;
	} bcx_mem_type;

	// Result returned to the processor
	typedef struct packed {
		logic [3:0] cc;
		logic ccWrite;
		logic [31:0] regValue;
		logic regWrite;
		logic [23:0] branchTarget;
		logic branch;
	} bcx_result_type;

endpackage

// >>> hw/bcx_exec.sv
// Execution datapath for bit, residual, translate and list-add operations
//
// Behaviour
// - Register value is bit offset from operand byte address, bit 0 leftmost.
// - Test bit reports bit state in condition code, changes nothing.
// - Set bit writes the addressed bit to one, others unchanged.
// - Clear bit forces the addressed bit to zero, others unchanged.
// - Invert bit complements the addressed bit, others unchanged.
// - Bit operations give code 0010 if bit was one, else 0000.
// - Residual ops fold register bits 24:31 into memory halfword, write back.
// - Twelve-bit residual uses six low character bits and constant 0f01.
// - Sixteen-bit residual uses all eight character bits and constant a001.
// - Residual ops leave register and condition code unchanged.
// - Read table pointer; 256 halfword entries indexed by twice character.
// - Entry bit 0 set loads entry bits 8:15 zero-extended into register.
// - Entry bit 0 clear branches to entry bits 1:15 shifted left one.
// - Tally equal to slot count: overflow set, nothing inserted.
// - Otherwise tally increments, pointer updates, register word is stored.
// - Top add decrements top pointer, wrapping zero to maximum slot.
// - Bottom add stores at bottom pointer, then increments with wrap.
// - List code 0100 on overflow, else 0000; header after element.
`timescale 1ns/1ps

module bcx_exec (
	input wire logic core_clk,
	input wire logic resetn,
	input wire bcx_pkg::bcx_cmd_type cmd,
	input wire logic cmdValid,
	output logic cmdReady,
	output bcx_pkg::bcx_mem_type memReq,
	output logic memValid,
	input wire logic memReady,
	input wire logic [31:0] memReadData,
	input wire logic memReadValid,
	output bcx_pkg::bcx_result_type result,
	output logic resultValid
);
	import bcx_pkg::*;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_READ = 9'h002,
		ST_WAIT = 9'h004,
		ST_READ2 = 9'h008,
		ST_WAIT2 = 9'h010,
		ST_HDR = 9'h020,
		ST_WAITH = 9'h040,
		ST_WRITE = 9'h080,
		ST_DONE = 9'h100
	} bcx_state_type;

	bcx_state_type state_reg, state_next;
	bcx_cmd_type cmd_reg, cmd_next;
	bcx_mem_type mem_reg, mem_next;
	logic memValid_reg, memValid_next;
	bcx_result_type res_reg, res_next;
	logic resValid_reg, resValid_next;
	logic [31:0] word_reg, word_next;
	logic [15:0] slots_reg, slots_next;
	logic [15:0] used_reg, used_next;
	logic [15:0] top_reg, top_next;
	logic [15:0] bottom_reg, bottom_next;
	logic [2:0] step_reg, step_next;

	// Derived values for the bit, residual and list operations
	logic [23:0] byteAddr;
	logic [2:0] bitPos;
	logic oldBit;
	logic [7:0] bitMask;
	logic [7:0] newByte;
	logic isBitOp, isCheck, isList, isTop;
	logic [15:0] residual;
	logic [15:0] newTop, newBottom, slotIndex;

	assign isBitOp = (cmd_reg.opcode[7:2] == OP_TEST_BIT[7:2]);
	assign isCheck = (cmd_reg.opcode == OP_CHECK_TWELVE) ||
		(cmd_reg.opcode == OP_CHECK_SIXTEEN);
	assign isList = (cmd_reg.opcode == OP_LIST_TOP) ||
		(cmd_reg.opcode == OP_LIST_BOTTOM);
	assign isTop = (cmd_reg.opcode == OP_LIST_TOP);

	// Byte holding the bit and its left-to-right position
	assign byteAddr = cmd_reg.address + cmd_reg.operand[26:3];
	assign bitPos = cmd_reg.operand[2:0];
	assign bitMask = 8'h80 >> bitPos;
	assign oldBit = |(word_reg[7:0] & bitMask);

	// Modified byte for set, clear and invert
	always_comb begin
		case (cmd_reg.opcode)
			OP_SET_BIT: newByte = word_reg[7:0] | bitMask;
			OP_CLEAR_BIT: newByte = word_reg[7:0] & ~bitMask;
			OP_INVERT_BIT: newByte = word_reg[7:0] ^ bitMask;
			default: newByte = word_reg[7:0];
		endcase
	end

	// Reflected residual fold, one bit of the character per step
	always_comb begin
		logic [15:0] r;
		logic [15:0] poly;
		logic [3:0] count;
		logic [7:0] ch;
		r = word_reg[15:0];
		poly = (cmd_reg.opcode == OP_CHECK_TWELVE) ?
			POLY_TWELVE : POLY_SIXTEEN;
		count = (cmd_reg.opcode == OP_CHECK_TWELVE) ?
			BITS_TWELVE : BITS_SIXTEEN;
		ch = (cmd_reg.opcode == OP_CHECK_TWELVE) ?
			{2'h0, cmd_reg.operand[5:0]} : cmd_reg.operand[7:0];
		r = r ^ {8'h00, ch};
		for (int i = 0; i < 8; i++) begin
			if (4'(i) < count) begin
				if (r[0]) begin
					r = (r >> 1) ^ poly;
				end else begin
					r = r >> 1;
				end
			end
		end
		residual = r;
	end

	// List pointer arithmetic with wrap
	assign newTop = (top_reg == 16'h0000) ? (slots_reg - 16'h0001) :
		(top_reg - 16'h0001);
	assign newBottom = ((bottom_reg + 16'h0001) > (slots_reg - 16'h0001)) ?
		16'h0000 : (bottom_reg + 16'h0001);
	assign slotIndex = isTop ? newTop : bottom_reg;

	// Sequencer: memory reads, compute, writes, result
	always_comb begin
		state_next = state_reg;
		cmd_next = cmd_reg;
		mem_next = mem_reg;
		memValid_next = memValid_reg;
		res_next = res_reg;
		resValid_next = 1'b0;
		word_next = word_reg;
		slots_next = slots_reg;
		used_next = used_reg;
		top_next = top_reg;
		bottom_next = bottom_reg;
		step_next = step_reg;
		if (memValid_reg && memReady) begin
			memValid_next = 1'b0;
		end
		case (state_reg)
			ST_IDLE: begin
				if (cmdValid) begin
					cmd_next = cmd;
					step_next = 3'h0;
					res_next = '0;
					state_next = ST_READ;
				end
			end
			ST_READ: begin
				// First read: bit byte, residual, table pointer or header
				memValid_next = 1'b1;
				mem_next.write = 1'b0;
				mem_next.data = 32'h00000000;
				if (isBitOp) begin
					mem_next.size = SZ_BYTE;
					mem_next.address = byteAddr;
				end else if (isCheck) begin
					mem_next.size = SZ_HALF;
					mem_next.address = cmd_reg.address;
				end else begin
					mem_next.size = SZ_WORD;
					mem_next.address = cmd_reg.address + (isList ?
						HDR_SLOTS_OFS : 24'h000000);
				end
				state_next = ST_WAIT;
			end
			ST_WAIT: begin
				if (memReadValid) begin
					word_next = memReadData;
					if (isList) begin
						slots_next = memReadData[31:16];
						used_next = memReadData[15:0];
						state_next = ST_HDR;
					end else if (isBitOp || isCheck) begin
						state_next = ST_WRITE;
					end else begin
						state_next = ST_READ2;
					end
				end
			end
			ST_READ2: begin
				// Table entry at pointer plus twice the character
				memValid_next = 1'b1;
				mem_next.write = 1'b0;
				mem_next.size = SZ_HALF;
				mem_next.address = word_reg[23:0] +
					{15'h0000, cmd_reg.operand[7:0], 1'b0};
				state_next = ST_WAIT2;
			end
			ST_WAIT2: begin
				if (memReadValid) begin
					if (memReadData[15]) begin
						res_next.regValue = {24'h000000, memReadData[7:0]};
						res_next.regWrite = 1'b1;
					end else begin
						res_next.branchTarget =
							{8'h00, memReadData[14:0], 1'b0};
						res_next.branch = 1'b1;
					end
					state_next = ST_DONE;
				end
			end
			ST_HDR: begin
				// Second header word holds the two pointers
				if (step_reg == 3'h0) begin
					memValid_next = 1'b1;
					mem_next.write = 1'b0;
					mem_next.size = SZ_WORD;
					mem_next.address = cmd_reg.address + HDR_TOP_OFS;
					step_next = 3'h1;
					state_next = ST_WAITH;
				end else if (used_reg == slots_reg) begin
					res_next.cc = CC_OVERFLOW;
					res_next.ccWrite = 1'b1;
					state_next = ST_DONE;
				end else begin
					state_next = ST_WRITE;
				end
			end
			ST_WAITH: begin
				if (memReadValid) begin
					top_next = memReadData[31:16];
					bottom_next = memReadData[15:0];
					state_next = ST_HDR;
				end
			end
			ST_WRITE: begin
				// Writes issue one at a time once memory took the last one
				if (!memValid_reg || memReady) begin
					memValid_next = 1'b1;
					mem_next.write = 1'b1;
					state_next = ST_WRITE;
					if (isBitOp) begin
						res_next.cc = oldBit ? CC_GREATER : CC_ZERO;
						res_next.ccWrite = 1'b1;
						if (cmd_reg.opcode == OP_TEST_BIT) begin
							memValid_next = 1'b0;
						end else begin
							mem_next.size = SZ_BYTE;
							mem_next.address = byteAddr;
							mem_next.data = {24'h000000, newByte};
						end
						state_next = ST_DONE;
					end else if (isCheck) begin
						// Register and code untouched
						mem_next.size = SZ_HALF;
						mem_next.address = cmd_reg.address;
						mem_next.data = {16'h0000, residual};
						state_next = ST_DONE;
					end else begin
						step_next = step_reg + 3'h1;
						case (step_reg)
							3'h1: begin
								// Element first, header afterwards
								mem_next.size = SZ_WORD;
								mem_next.address = cmd_reg.address +
									LIST_SLOT0_OFS + {6'h00, slotIndex, 2'h0};
								mem_next.data = cmd_reg.operand;
							end
							3'h2: begin
								mem_next.size = SZ_HALF;
								mem_next.address = cmd_reg.address + HDR_USED_OFS;
								mem_next.data = {16'h0000, used_reg + 16'h0001};
							end
							default: begin
								mem_next.size = SZ_HALF;
								mem_next.address = cmd_reg.address +
									(isTop ? HDR_TOP_OFS : HDR_BOTTOM_OFS);
								mem_next.data = {16'h0000,
									isTop ? newTop : newBottom};
								res_next.cc = CC_ZERO;
								res_next.ccWrite = 1'b1;
								state_next = ST_DONE;
							end
						endcase
					end
				end
			end
			ST_DONE: begin
				// Result waits until the last write is taken
				if (!memValid_reg || memReady) begin
					resValid_next = 1'b1;
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// State registers
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
			cmd_reg <= '0;
			mem_reg <= '0;
			memValid_reg <= 1'b0;
			res_reg <= '0;
			resValid_reg <= 1'b0;
			word_reg <= 32'h00000000;
			slots_reg <= 16'h0000;
			used_reg <= 16'h0000;
			top_reg <= 16'h0000;
			bottom_reg <= 16'h0000;
			step_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			cmd_reg <= cmd_next;
			mem_reg <= mem_next;
			memValid_reg <= memValid_next;
			res_reg <= res_next;
			resValid_reg <= resValid_next;
			word_reg <= word_next;
			slots_reg <= slots_next;
			used_reg <= used_next;
			top_reg <= top_next;
			bottom_reg <= bottom_next;
			step_reg <= step_next;
		end
	end

	assign cmdReady = (state_reg == ST_IDLE);
	assign memReq = mem_reg;
	assign memValid = memValid_reg;
	assign result = res_reg;
	assign resultValid = resValid_reg;

endmodule

// >>> verif/bcx_exec_chk.sv
// Port checker for the execution datapath
`timescale 1ns/1ps
module bcx_exec_chk (
	input wire logic core_clk,
	input wire logic resetn,
	input wire bcx_pkg::bcx_cmd_type cmd,
	input wire logic cmdValid,
	input wire logic cmdReady,
	input wire bcx_pkg::bcx_mem_type memReq,
	input wire logic memValid,
	input wire logic memReady,
	input wire logic [31:0] memReadData,
	input wire logic memReadValid,
	input wire bcx_pkg::bcx_result_type result,
	input wire logic resultValid
);
	import bcx_pkg::*;
	bcx_cmd_type held_reg;
	bcx_cmd_type held_next;
	logic isBit, isCheck, isList, isXlate;
	logic [23:0] bitAddr;
	// Keep the command in flight so that answers can be tied to it
	always_comb begin
		held_next = held_reg;
		if (cmdValid && cmdReady) begin
			held_next = cmd;
		end
	end
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			held_reg <= '0;
		end else begin
			held_reg <= held_next;
		end
	end
	// Opcode groups; high offset bits are ignored by choice
	assign isBit = held_reg.opcode[7:2] == 6'h1d;
	assign isCheck = held_reg.opcode[7:1] == 7'h2f;
	assign isList = held_reg.opcode[7:1] == 7'h32;
	assign isXlate = held_reg.opcode == OP_TRANSLATE;
	assign bitAddr = held_reg.address + held_reg.operand[26:3];

	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence s_take;
		cmdValid && cmdReady;
	endsequence
	sequence s_answer;
		##[2:400] resultValid;
	endsequence

	a_take_busy: assert property (s_take |=> !cmdReady)
		else $error("ready stayed high after a take");
	a_answer_bound: assert property (s_take |-> s_answer)
		else $error("no answer in time");
	a_result_pulse: assert property (resultValid |=> !resultValid)
		else $error("result pulse too long");
	a_mem_hold: assert property (memValid && !memReady |=>
		memValid && $stable(memReq)) else $error("request dropped");
	a_bit_byte: assert property (memValid && isBit |->
		memReq.size == SZ_BYTE && memReq.address == bitAddr)
		else $error("wrong bit byte");
	a_test_nowrite: assert property (
		memValid && held_reg.opcode == OP_TEST_BIT |-> !memReq.write)
		else $error("test wrote memory");
	a_bit_cc: assert property (resultValid && isBit |->
		result.ccWrite && !result.regWrite &&
		(result.cc == CC_ZERO || result.cc == CC_GREATER))
		else $error("bad bit code");
	a_check_half: assert property (memValid && isCheck |->
		memReq.size == SZ_HALF && memReq.address == held_reg.address)
		else $error("wrong residual access");
	a_check_keep: assert property (resultValid && isCheck |->
		!result.ccWrite && !result.regWrite && !result.branch)
		else $error("residual touched state");
	a_xlate_out: assert property (resultValid && isXlate |->
		!result.ccWrite && (result.regWrite != result.branch) &&
		(!result.regWrite || result.regValue[31:8] == 24'h0))
		else $error("bad translate result");
	a_list_cc: assert property (resultValid && isList |->
		result.ccWrite && (result.cc == CC_ZERO || result.cc == CC_OVERFLOW))
		else $error("bad list code");
endmodule
bind bcx_exec bcx_exec_chk i_chk (.core_clk(core_clk), .resetn(resetn),
	.cmd(cmd), .cmdValid(cmdValid), .cmdReady(cmdReady), .memReq(memReq),
	.memValid(memValid), .memReady(memReady), .memReadData(memReadData),
	.memReadValid(memReadValid), .result(result), .resultValid(resultValid));

// >>> verif/bcx_mem_model.sv
// Main memory model answering the datapath's requests
`timescale 1ns/1ps
module bcx_mem_model (
	input wire logic core_clk,
	input wire logic resetn,
	input wire bcx_pkg::bcx_mem_type memReq,
	input wire logic memValid,
	input wire logic slow,
	output logic memReady,
	output logic [31:0] memReadData,
	output logic memReadValid
);
	import bcx_pkg::*;
	logic [7:0] mem [0:4095];
	logic [11:0] a;
	assign a = memReq.address[11:0];
	// Ready follows a request by a cycle or more; slow mode stalls at random
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			memReady <= 1'b0;
			memReadValid <= 1'b0;
			memReadData <= 32'h0;
		end else begin
			memReadValid <= 1'b0;
			memReadData <= ~memReadData; // Stale data inverts every cycle
			memReady <= memValid && !memReady && (!slow || $urandom_range(3) == 0);
			if (memValid && memReady && !memReq.write) begin
				memReadValid <= 1'b1;
				case (memReq.size)
					SZ_BYTE: memReadData <= {24'h0, mem[a]};
					SZ_HALF: memReadData <= {16'h0, mem[a], mem[a + 12'h1]};
					default: memReadData <= {mem[a], mem[a + 12'h1],
						mem[a + 12'h2], mem[a + 12'h3]};
				endcase
			end else if (memValid && memReady) begin
				case (memReq.size)
					SZ_BYTE: mem[a] <= memReq.data[7:0];
					SZ_HALF: {mem[a], mem[a + 12'h1]} <= memReq.data[15:0];
					default: {mem[a], mem[a + 12'h1], mem[a + 12'h2],
						mem[a + 12'h3]} <= memReq.data;
				endcase
			end
		end
	end
endmodule

// >>> verif/test_bcx_exec.sv
// Self-checking bench for the execution datapath
`timescale 1ns/1ps
module test_bcx_exec;
	import bcx_pkg::*;
	logic core_clk, resetn, cmdValid, cmdReady, memValid, memReady;
	logic memReadValid, resultValid, slow;
	bcx_cmd_type cmd;
	bcx_mem_type memReq;
	bcx_result_type result;
	logic [31:0] memReadData, v;
	logic [7:0] op, b, n, m;
	logic [15:0] h, e;
	int n_fail, num_checks, used, top, bot, s;
	bcx_exec i_dut (.core_clk(core_clk), .resetn(resetn), .cmd(cmd),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .memReq(memReq),
		.memValid(memValid), .memReady(memReady), .memReadData(memReadData),
		.memReadValid(memReadValid), .result(result), .resultValid(resultValid));
	bcx_mem_model i_mem (.core_clk(core_clk), .resetn(resetn), .memReq(memReq),
		.memValid(memValid), .slow(slow), .memReady(memReady),
		.memReadData(memReadData), .memReadValid(memReadValid));
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	function automatic logic [15:0] mh(int ad);
		return {i_mem.mem[ad], i_mem.mem[ad + 1]};
	endfunction
	function automatic logic [7:0] bitop(logic [7:0] o, d, k);
		case (o)
			OP_SET_BIT: return d | k;
			OP_CLEAR_BIT: return d & ~k;
			OP_INVERT_BIT: return d ^ k;
			default: return d;
		endcase
	endfunction
	// Reflected residual, low character bit first
	function automatic logic [15:0] crcf(logic [15:0] r, logic [7:0] c, bit six);
		logic lsb;
		for (int i = 0; i < (six ? 6 : 8); i++) begin
			lsb = r[0] ^ c[i];
			r = r >> 1;
			if (lsb) r = r ^ (six ? POLY_TWELVE : POLY_SIXTEEN);
		end
		return r;
	endfunction
	// One command presented for a single cycle, then a bounded wait for its answer
	task automatic run(logic [7:0] o, logic [31:0] opnd, logic [23:0] ad);
		@(posedge core_clk);
		cmd <= '{o, opnd, ad};
		cmdValid <= 1'b1;
		slow <= 1'($urandom_range(1));
		@(posedge core_clk);
		cmdValid <= 1'b0;
		for (int i = 0; i < 500 && resultValid !== 1'b1; i++) begin
			@(posedge core_clk);
			#1;
		end
		chk("answer", resultValid, 1);
	endtask
	// Hang guard, well beyond the expected run length
	initial begin
		repeat (30000) @(posedge core_clk);
		n_fail++;
		stop_test();
	end
	initial begin
		cmd = '0;
		cmdValid = 1'b0;
		slow = 1'b0;
		resetn = 1'b0;
		void'($urandom(88));
		for (int k = 0; k < 4096; k++) i_mem.mem[k] = 8'($urandom);
		repeat (5) @(posedge core_clk);
		resetn <= 1'b1;
		// Bit ops on a halfword-aligned array, first eight offsets cover every bit position
		for (int k = 0; k < 32; k++) begin
			op = OP_TEST_BIT + 8'(k % 4);
			v = (k < 8) ? 32'(k * 7) : $urandom_range(2047);
			b = i_mem.mem[12'h400 + v[10:3]];
			n = i_mem.mem[12'h401 + v[10:3]];
			m = 8'h80 >> v[2:0];
			run(op, v, 24'h400);
			chk("bit_cc", result.cc, (b & m) ? CC_GREATER : CC_ZERO);
			chk("bit_mem", i_mem.mem[12'h400 + v[10:3]],
				bitop(op, b, m));
			chk("bit_next", i_mem.mem[12'h401 + v[10:3]], n);
		end
		// Residuals of both widths on a halfword boundary
		for (int k = 0; k < 16; k++) begin
			if (!k[0]) i_mem.mem[12'h500][7:4] = 4'h0;
			h = mh(12'h500);
			v = $urandom;
			run(k[0] ? OP_CHECK_SIXTEEN : OP_CHECK_TWELVE, v, 24'h500);
			chk("residual", mh(12'h500),
				crcf(h, v[7:0], !k[0]));
			chk("res_flags", {result.ccWrite, result.regWrite}, 0);
		end
		// Translate through a table pointer held on a fullword boundary
		{i_mem.mem[12'h100], i_mem.mem[12'h101]} = 16'h0;
		{i_mem.mem[12'h102], i_mem.mem[12'h103]} = 16'h0200;
		for (int k = 0; k < 16; k++) begin
			v = (k == 0) ? 32'hffff_ffff : $urandom;
			i_mem.mem[12'h200 + 2 * v[7:0]][7] = k[0];
			e = mh(12'h200 + 2 * v[7:0]);
			run(OP_TRANSLATE, v, 24'h100);
			chk("xl_kind", {result.regWrite, result.branch}, e[15] ? 2 : 1);
			chk("xl_val", e[15] ? result.regValue : result.branchTarget,
				e[15] ? {24'h0, e[7:0]} : {e[14:0], 1'b0});
		end
		// Five-slot list: three on top, then bottom until it overflows
		{i_mem.mem[12'h600], i_mem.mem[12'h601]} = 16'h0005;
		for (int k = 2; k < 8; k++) i_mem.mem[12'h600 + k] = 8'h0;
		used = 0;
		top = 0;
		bot = 0;
		for (int k = 0; k < 7; k++) begin
			op = (k < 3) ? OP_LIST_TOP : OP_LIST_BOTTOM;
			v = $urandom;
			run(op, v, 24'h600);
			chk("list_cc", result.cc,
				(used == 5) ? CC_OVERFLOW : CC_ZERO);
			if (used < 5) begin
				if (k < 3) top = (top == 0) ? 4 : top - 1;
				s = (k < 3) ? top : bot;
				if (k >= 3) bot = (bot == 4) ? 0 : bot + 1;
				used++;
				chk("slot", {mh(12'h608 + 4 * s), mh(12'h60a + 4 * s)}, v);
			end
			chk("used", mh(12'h602), used);
			chk("ptrs", {mh(12'h604), mh(12'h606)},
				{16'(top), 16'(bot)});
		end
		stop_test();
	end
endmodule
